// file: rtl/dip_pkg.sv
// constants shared by the power-fail ride-through supervisor
package dip_pkg;
   localparam int CLK_HZ = 40000000; // core clock rate
   localparam int MS_PER_S = 1000; // milliseconds per second
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S; // 40000 cycles per ms
   localparam int MS_CNT_W = 16; // width of the sub-millisecond prescaler
   localparam int DIP_TIME_W = 16; // width of the detection time setting
   localparam logic [15:0] DIP_TIME_RST = 16'h00C8; // 200 ms after init
   localparam int SAFE_DIP_MS = 200; // dip length that allows normal power-down
   localparam int OUT_ASSIGN_N = 3; // output assignment settings first..last
   localparam int CLASS_W = 2; // amplifier class code width
   localparam logic [1:0] CLASS_LOW = 2'h0; // 158 V DC class
   localparam logic [1:0] CLASS_MID = 2'h1; // 200 V DC class
   localparam logic [1:0] CLASS_HIGH = 2'h2; // 380 V DC class
   localparam int UV_LOW_V = 158; // undervoltage levels in volts DC
   localparam int UV_MID_V = 200;
   localparam int UV_HIGH_V = 380;
   localparam int BUS_V_W = 10; // bus voltage sample width, volts
   localparam int CODE_W = 4; // output function code width
endpackage : dip_pkg

// file: rtl/dip_supervisor.sv
// power-fail ride-through supervisor for a servo amplifier
// Operation
// - brake interlock stays on during ride-through
// - optional acceleration torque limit during dip
// - bus drop alarm regardless of dip timer
// - dynamic brake assigned means servo-off on dip
// - detection time defaults to 200 ms
// - long deep dip may power down early
// - control drop alarm when dip exceeds time
// - ride-through output on at dip detection
// - brake interlock off when alarm raised
// - undervoltage alarm on bus drop in dip
// - short clean dip keeps running, no alarm
// - ride-through enabled by dedicated setting
// - undervoltage level chosen by amplifier class
module dip_supervisor
   import dip_pkg::*;
#(
   parameter int DIP_W = dip_pkg::DIP_TIME_W // dip time width
) (
   input wire logic CORE_CLK_IN, // core clock
   input wire logic SYS_RST_IN, // async reset, active high
   input wire logic CLK_EN_IN, // clock enable, freezes state when low
   input wire logic CTRL_SUPPLY_OK_IN, // control supply present
   input wire logic LOW_INPUT_70_IN, // input below 70 percent rated
   input wire logic [dip_pkg::BUS_V_W-1:0] BUS_VOLT_IN, // bus voltage, volts
   input wire logic [dip_pkg::CLASS_W-1:0] AMP_CLASS_IN, // amplifier class
   input wire logic RIDE_THROUGH_SETTING_IN, // ride-through enable
   input wire logic DIP_TORQUE_LIMIT_SELECT_IN, // torque limit on dip
   input wire logic DIP_DETECT_TIME_WE_IN, // write strobe for detect time
   input wire logic [DIP_W-1:0] DIP_DETECT_TIME_IN, // new detect time, ms
   input wire logic [dip_pkg::OUT_ASSIGN_N*dip_pkg::CODE_W-1:0] OUTPUT_ASSIGN_IN, // pin codes
   input wire logic [dip_pkg::CODE_W-1:0] DB_CODE_IN, // code of dynamic brake output
   input wire logic ACCEL_IN, // motor is accelerating
   input wire logic SERVO_ON_REQ_IN, // servo-on request
   input wire logic ALARM_RESET_IN, // clears latched alarms
   output logic [DIP_W-1:0] DIP_DETECT_TIME_OUT, // current detect time
   output logic RIDE_THROUGH_ACTIVE_OUT, // ride-through in progress
   output logic BRAKE_INTERLOCK_OUT, // brake released while high
   output logic MALFUNCTION_OUT, // any alarm latched
   output logic WARNING_OUT, // warning while riding through a dip
   output logic UNDERVOLTAGE_ALARM_OUT, // undervoltage alarm
   output logic CONTROL_SUPPLY_DROP_ALARM_OUT, // control supply drop alarm
   output logic MAIN_BUS_DROP_ALARM_OUT, // main bus drop alarm
   output logic TORQUE_LIMIT_OUT, // limit acceleration torque
   output logic BASE_ON_OUT, // base circuit enable
   output logic POWER_DOWN_OK_OUT // normal power-down permitted
);
   import dip_pkg::*;

   // the 200 ms default needs 8 bits; the setting ports carry at most 16
   if (DIP_W < 8 || DIP_W > 16) begin : g_bad_width
      $error("DIP_W out of range");
   end

   typedef enum logic [1:0] {RUN, RIDE, FAULT} state_type; // supervisor states

   state_type state_r; // current state
   logic [MS_CNT_W-1:0] pre_r; // cycles within current ms
   logic [DIP_W-1:0] ms_r; // elapsed dip ms
   logic [DIP_W-1:0] dip_time_r; // configured detection time
   logic uv_alm_r, ctrl_alm_r, bus_alm_r; // latched alarms
   logic db_assigned; // dynamic brake on an output pin
   logic under_level; // bus at or below undervoltage level
   logic [BUS_V_W-1:0] uv_level; // selected undervoltage level
   logic dip; // control supply lost
   logic ride_ok; // ride-through allowed for this dip
   logic alarm_any; // any alarm latched
   logic tick; // one-ms pulse

   // undervoltage level by amplifier class
   always_comb begin
      case (AMP_CLASS_IN)
         CLASS_MID: uv_level = BUS_V_W'(UV_MID_V);
         CLASS_HIGH: uv_level = BUS_V_W'(UV_HIGH_V);
         default: uv_level = BUS_V_W'(UV_LOW_V);
      endcase
   end

   // dynamic brake on any assigned output forbids ride-through
   always_comb begin
      db_assigned = 1'b0;
      for (int i = 0; i < OUT_ASSIGN_N; i++) begin
         if (OUTPUT_ASSIGN_IN[i*CODE_W +: CODE_W] == DB_CODE_IN) db_assigned = 1'b1;
      end
   end

   assign dip = !CTRL_SUPPLY_OK_IN;
   assign under_level = BUS_VOLT_IN <= uv_level;
   assign ride_ok = RIDE_THROUGH_SETTING_IN && !db_assigned;
   assign alarm_any = uv_alm_r || ctrl_alm_r || bus_alm_r;
   assign tick = pre_r == MS_CNT_W'(CYC_PER_MS - 1);

   // detection time setting, 200 ms after reset
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         dip_time_r <= DIP_W'(DIP_TIME_RST);
      end else if (CLK_EN_IN && DIP_DETECT_TIME_WE_IN) begin
         dip_time_r <= DIP_DETECT_TIME_IN;
      end
   end

   // dip timer: ms prescaler and ms count, cleared on recovery
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         pre_r <= '0;
         ms_r <= '0;
      end else if (CLK_EN_IN) begin
         if (!dip) begin
            pre_r <= '0;
            ms_r <= '0;
         end else if (tick) begin
            pre_r <= '0;
            if (ms_r != '1) ms_r <= ms_r + 1'b1; // saturate, never wraps
         end else begin
            pre_r <= pre_r + 1'b1;
         end
      end
   end

   // supervisor state machine
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_r <= RUN;
      end else if (CLK_EN_IN) begin
         case (state_r)
            RUN: begin
               if (alarm_any) state_r <= FAULT;
               else if (dip && ride_ok) state_r <= RIDE;
               else if (dip) state_r <= FAULT; // servo-off on dip
            end
            RIDE: begin
               if (alarm_any) state_r <= FAULT;
               else if (!dip) state_r <= RUN; // short clean dip
            end
            FAULT: begin
               if (ALARM_RESET_IN && !dip && !under_level) state_r <= RUN;
            end
            default: state_r <= RUN;
         endcase
      end
   end

   // alarm latches; a new cause wins over the reset request
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         uv_alm_r <= 1'b0;
         ctrl_alm_r <= 1'b0;
         bus_alm_r <= 1'b0;
      end else if (CLK_EN_IN) begin
         if (ALARM_RESET_IN) begin
            uv_alm_r <= 1'b0;
            ctrl_alm_r <= 1'b0;
            bus_alm_r <= 1'b0;
         end
         // bus at level during a dip: undervoltage even with ride-through
         if (dip && under_level) uv_alm_r <= 1'b1;
         // bus drop alarm does not wait for the dip timer
         if (under_level) bus_alm_r <= 1'b1;
         // dip longer than the detection time
         if (dip && ms_r > dip_time_r) ctrl_alm_r <= 1'b1;
         // without ride-through any dip is at once a control supply alarm
         if (dip && !RIDE_THROUGH_SETTING_IN) ctrl_alm_r <= 1'b1;
      end
   end

   // outputs
   assign DIP_DETECT_TIME_OUT = dip_time_r;
   assign RIDE_THROUGH_ACTIVE_OUT = (state_r == RIDE);
   // brake stays released through ride-through, drops with any alarm
   assign BRAKE_INTERLOCK_OUT = SERVO_ON_REQ_IN && !alarm_any && state_r != FAULT;
   assign BASE_ON_OUT = BRAKE_INTERLOCK_OUT;
   assign MALFUNCTION_OUT = alarm_any;
   assign WARNING_OUT = state_r == RIDE; // warning while riding through
   assign UNDERVOLTAGE_ALARM_OUT = uv_alm_r;
   assign CONTROL_SUPPLY_DROP_ALARM_OUT = ctrl_alm_r;
   assign MAIN_BUS_DROP_ALARM_OUT = bus_alm_r;
   // torque limited only while accelerating in a dip
   assign TORQUE_LIMIT_OUT = DIP_TORQUE_LIMIT_SELECT_IN && state_r == RIDE && ACCEL_IN;
   // deep dip past 200 ms may power down whatever the setting
   assign POWER_DOWN_OK_OUT = dip && LOW_INPUT_70_IN && ms_r > DIP_W'(SAFE_DIP_MS);

   AST_RIDE_OUT: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && state_r == RUN && !alarm_any && dip && ride_ok) |=> RIDE_THROUGH_ACTIVE_OUT)
      else $error("ride-through output not raised on dip");
   // a dip with no alarm cause must not drop a held brake interlock
   AST_BRAKE_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && dip && ride_ok && BRAKE_INTERLOCK_OUT && !under_level
         && ms_r <= dip_time_r) |=> (BRAKE_INTERLOCK_OUT || !SERVO_ON_REQ_IN))
      else $error("brake dropped during ride-through");
   AST_BRAKE_OFF: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && dip && ms_r > dip_time_r) |=> !BRAKE_INTERLOCK_OUT)
      else $error("brake interlock on with alarm");
   AST_CTRL_ALM: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && dip && ms_r > dip_time_r) |=> CONTROL_SUPPLY_DROP_ALARM_OUT)
      else $error("control drop alarm missing");
   AST_BUS_ALM: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && under_level) |=> MAIN_BUS_DROP_ALARM_OUT)
      else $error("bus drop alarm missing");
   AST_UV_ALM: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && dip && under_level && ms_r <= dip_time_r) |=> UNDERVOLTAGE_ALARM_OUT)
      else $error("undervoltage alarm missing");
   AST_TIMER_CLR: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && !dip) |=> (ms_r == '0 && pre_r == '0))
      else $error("dip timer not cleared on recovery");
   AST_DB_OFF: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && state_r == RUN && dip && db_assigned) |=> state_r == FAULT)
      else $error("dip with dynamic brake assigned did not stop");
   AST_TORQUE: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      TORQUE_LIMIT_OUT |-> (RIDE_THROUGH_ACTIVE_OUT && ACCEL_IN && DIP_TORQUE_LIMIT_SELECT_IN))
      else $error("torque limit outside dip");
   AST_NO_ALM: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && state_r == RIDE && !alarm_any && RIDE_THROUGH_SETTING_IN && !under_level
         && ms_r <= dip_time_r) |=> !MALFUNCTION_OUT)
      else $error("alarm raised on short clean dip");
   AST_NO_RIDE: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (CLK_EN_IN && dip && !RIDE_THROUGH_SETTING_IN) |=> CONTROL_SUPPLY_DROP_ALARM_OUT)
      else $error("dip without ride-through raised no alarm");
   // a frozen enable must also freeze the dip timer, or dips would be timed long
   AST_FREEZE: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      !CLK_EN_IN |=> ($stable(state_r) && $stable(ms_r) && $stable(pre_r)
         && $stable(alarm_any)))
      else $error("state moved with clock enable low");
endmodule : dip_supervisor

// file: bench/supply_model.sv
// ideal supply and bus-voltage detectors on the block's far side
module supply_model (
   input wire logic dip_in, // bench asks for a control-supply dip
   input wire logic deep_in, // dip goes below 70 percent rated
   input wire logic [9:0] bus_in, // bus voltage to present, volts
   output logic ok_out, // control supply present
   output logic low70_out, // input below 70 percent
   output logic [9:0] volt_out // bus voltage seen by the block
);
   timeunit 1ns;
   timeprecision 100ps;
   // level sensors with no hysteresis; a real one would be slower, not kinder
   assign ok_out = !dip_in;
   assign low70_out = dip_in & deep_in; // deep only counts inside a dip
   assign volt_out = bus_in;
endmodule : supply_model

// file: bench/test_dip_supervisor.sv
// self-checking bench for the ride-through supervisor
module test_dip_supervisor;
   timeunit 1ns;
   timeprecision 100ps;
   import dip_pkg::*;
   logic clk, rst, dip, deep, accel, son, arst, we, sel, rts, cen; // stimulus
   logic [9:0] bus; // requested bus voltage
   logic [1:0] cls; // amplifier class
   logic [15:0] dt_in; // detect time to load
   logic [11:0] asg; // output assignments
   logic [3:0] dbc; // dynamic brake code
   logic ok, low70; // from the supply model
   logic [9:0] volt; // from the supply model
   logic [15:0] dt_out; // detect time readback
   logic rta, brk, mal, warning_out, uva, csa, mba, tql, bon, pdo; // design outputs
   int num_errors, checked; // verdict counters
   supply_model sup_u (.dip_in(dip), .deep_in(deep), .bus_in(bus), .ok_out(ok),
      .low70_out(low70), .volt_out(volt));
   dip_supervisor dut_u (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(cen),
      .CTRL_SUPPLY_OK_IN(ok), .LOW_INPUT_70_IN(low70), .BUS_VOLT_IN(volt),
      .AMP_CLASS_IN(cls), .RIDE_THROUGH_SETTING_IN(rts), .DIP_TORQUE_LIMIT_SELECT_IN(sel),
      .DIP_DETECT_TIME_WE_IN(we), .DIP_DETECT_TIME_IN(dt_in), .OUTPUT_ASSIGN_IN(asg),
      .DB_CODE_IN(dbc), .ACCEL_IN(accel), .SERVO_ON_REQ_IN(son), .ALARM_RESET_IN(arst),
      .DIP_DETECT_TIME_OUT(dt_out), .RIDE_THROUGH_ACTIVE_OUT(rta), .BRAKE_INTERLOCK_OUT(brk),
      .MALFUNCTION_OUT(mal), .WARNING_OUT(warning_out), .UNDERVOLTAGE_ALARM_OUT(uva),
      .CONTROL_SUPPLY_DROP_ALARM_OUT(csa), .MAIN_BUS_DROP_ALARM_OUT(mba),
      .TORQUE_LIMIT_OUT(tql), .BASE_ON_OUT(bon), .POWER_DOWN_OK_OUT(pdo));
   // 40 MHz core clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // advance n edges, then step off the edge to drive
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // one compare for every 16-bit or narrower result
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // alarm reset with supply back and bus high; held two edges so that a
   // ride still ending in fault is also released from fault
   task clr;
      arst = 1'b1;
      step(2);
      arst = 1'b0;
      step(1);
   endtask : clr
   task results;
      if (num_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // short clean dip with torque limit, after loading a 1 ms detect time
   task t_short;
      we = 1'b1;
      dt_in = 16'h0001;
      step(1);
      we = 1'b0;
      chk(dt_out, 16'h0001);
      dip = 1'b1;
      step(1);
      chk({rta, warning_out}, 16'h0003);
      chk(tql, 16'h0001);
      step(100);
      chk({brk, bon, mal}, 16'h0006);
      dip = 1'b0;
      step(2);
      chk({rta, mal, csa, uva, mba, brk}, 16'h0001);
   endtask : t_short
   // dip past 1 ms: alarm only once the count exceeds the setting
   task t_long;
      int n;
      n = 0;
      accel = 1'b0;
      dip = 1'b1;
      step(60000);
      chk({csa, rta}, 16'h0001);
      chk(tql, 16'h0000);
      while (csa !== 1'b1 && n < 30000) begin
         step(1);
         n++;
      end
      chk({csa, mal, brk}, 16'h0006);
      dip = 1'b0;
      clr();
      chk({csa, mal, brk}, 16'h0001);
   endtask : t_long
   // bus level per class, then undervoltage inside a dip
   task t_bus;
      int lv[4] = '{UV_LOW_V, UV_MID_V, UV_HIGH_V, UV_LOW_V}; // class 3 reads as low
      for (int i = 0; i < 4; i++) begin
         cls = 2'(i);
         bus = 10'(lv[i] + 1);
         step(2);
         chk(mba, 16'h0000);
         bus = 10'(lv[i]);
         step(2);
         chk({mba, mal}, 16'h0003);
         bus = 10'h3FF;
         clr();
      end
      cls = CLASS_LOW;
      dip = 1'b1;
      bus = 10'(UV_LOW_V);
      step(2);
      chk({uva, mba}, 16'h0003);
      dip = 1'b0;
      bus = 10'h3FF;
      clr();
   endtask : t_bus
   // dynamic brake assigned, then ride-through disabled: both refuse the dip
   task t_refuse;
      asg = 12'h512;
      dip = 1'b1;
      step(2);
      chk({bon, rta}, 16'h0000);
      dip = 1'b0;
      asg = 12'h123;
      clr();
      rts = 1'b0;
      dip = 1'b1;
      step(2);
      chk({csa, rta}, 16'h0002);
      dip = 1'b0;
      rts = 1'b1;
      clr();
      chk({bon, mal}, 16'h0002);
   endtask : t_refuse
   // enable low freezes the supervisor; a short deep dip may not power down
   task t_freeze;
      cen = 1'b0;
      dip = 1'b1;
      deep = 1'b1;
      step(3);
      chk({rta, brk}, 16'h0001);
      cen = 1'b1;
      step(1);
      chk({rta, tql, pdo}, 16'h0004);
      dip = 1'b0;
      deep = 1'b0;
      step(2);
      chk({rta, mal, brk}, 16'h0001);
   endtask : t_freeze
   // main sequence
   initial begin
      {dip, deep, accel, arst, we} = 5'h00;
      {son, sel, rts, rst} = 4'hF;
      cen = 1'b1;
      bus = 10'h3FF;
      cls = CLASS_LOW;
      dt_in = 16'h0000;
      asg = 12'h123;
      dbc = 4'h5;
      num_errors = 0;
      checked = 0;
      step(8);
      rst = 1'b0;
      chk(dt_out, DIP_TIME_RST);
      chk({rta, mal, brk}, 16'h0001);
      accel = 1'b1;
      t_short();
      t_long();
      t_bus();
      t_refuse();
      t_freeze();
      results();
   end
   // watchdog past the roughly 2 ms the run needs, inside the cycle budget
   initial begin
      #2400000;
      num_errors++;
      results();
   end
endmodule : test_dip_supervisor
